/* File: common/rdfm_pkg.sv */
// constants shared by the receive decimator and fine mixer
package rdfm_pkg;

    // sample and word widths
    localparam int SMP_W = 12;
    localparam int FREQ_W = 32;
    localparam int PHW_W = 20;
    localparam int TRIG_W = 16;
    localparam int ACC_W = 40;

    // half-band decimator shape
    localparam int TAPS = 43;
    localparam int CENTRE = 21;
    localparam int NZ_PAIRS = 11;
    localparam int COEF_W = 18;
    // first 22 taps: pairs at even offsets, entry 11 is the centre
    localparam logic signed [17:0] COEF [0:11] = '{
        18'sd9, -18'sd33, 18'sd88, -18'sd196, 18'sd387, -18'sd704,
        18'sd1210, -18'sd2024, 18'sd3432, -18'sd6485, 18'sd20700, 18'sd32768
    };
    // coefficient sum is 65536, so unity gain needs this shift
    localparam int DEC_SHIFT = 16;

    // mixer scaling: trig values are Q1.15
    localparam int MIX_SHIFT = 15;

    // cordic sine/cosine generator
    localparam int CORDIC_N = 14;
    localparam logic signed [17:0] CORDIC_GAIN = 18'sd19898;
    localparam logic signed [17:0] TRIG_MAX = 18'sd32767;
    localparam logic signed [16:0] ATAN [0:13] = '{
        17'sd8192, 17'sd4836, 17'sd2555, 17'sd1297, 17'sd651, 17'sd326, 17'sd163,
        17'sd81, 17'sd41, 17'sd20, 17'sd10, 17'sd5, 17'sd3, 17'sd1
    };

    // reset values
    localparam logic [31:0] PHASE_ACC_RST = 32'h0000_0000;
    localparam logic [11:0] SMP_RST = 12'h000;

endpackage

/* File: src/rdfm_nco_sincos.sv */
// cordic cosine and sine of a 16-bit phase, combinational
`timescale 1ns/1ps
`default_nettype none

module rdfm_nco_sincos (
    // phase, full turn is 2^16
    input wire logic [15:0] phase,
    // results, Q1.15
    output logic signed [15:0] cos_out,
    output logic signed [15:0] sin_out
);

    logic signed [17:0] x;
    logic signed [17:0] y;
    logic signed [17:0] xn;
    logic signed [16:0] z;
    logic flip;

    function automatic logic signed [15:0] clamp(input logic signed [17:0] v);
        if (v > rdfm_pkg::TRIG_MAX) begin
            clamp = rdfm_pkg::TRIG_MAX[15:0];
        end else if (v < -rdfm_pkg::TRIG_MAX) begin
            clamp = -rdfm_pkg::TRIG_MAX[15:0];
        end else begin
            clamp = v[15:0];
        end
    endfunction

    // rotation only converges within about +-90 deg, so the back half is folded by 180 deg
    always_comb begin
        flip = phase[15] ^ phase[14];
        z = flip ? {{1{~phase[15]}}, ~phase[15], phase[14:0]} : {{1{phase[15]}}, phase};
        x = rdfm_pkg::CORDIC_GAIN;
        y = 18'sh00000;
        xn = 18'sh00000;
        for (int i = 0; i < rdfm_pkg::CORDIC_N; i++) begin
            if (!z[16]) begin
                xn = x - (y >>> i);
                y = y + (x >>> i);
                z = z - rdfm_pkg::ATAN[i];
            end else begin
                xn = x + (y >>> i);
                y = y - (x >>> i);
                z = z + rdfm_pkg::ATAN[i];
            end
            x = xn;
        end
        cos_out = clamp(flip ? -x : x);
        sin_out = clamp(flip ? -y : y);
    end

endmodule

`default_nettype wire

/* File: src/rdfm_top.sv */
// receive half-band decimator by two followed by nco fine complex mixer
`timescale 1ns/1ps
`default_nettype none

module rdfm_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // adc sample streams
    input wire logic signed [11:0] ADC_A,
    input wire logic signed [11:0] ADC_B,
    input wire logic ADC_VALID,
    // controls
    input wire logic DEC_ENABLE,
    input wire logic [31:0] NCO_FREQ,
    input wire logic [19:0] NCO_PHASE,
    // complex output
    output logic signed [11:0] OUT_I,
    output logic signed [11:0] OUT_Q,
    output logic OUT_VALID
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // round half up, then clamp to the sample range
    function automatic logic signed [11:0] rnd_sat(input logic signed [39:0] v, input int sh);
        logic signed [39:0] r;
        r = (v + (40'sd1 <<< (sh - 1))) >>> sh;
        if (r > 40'sd2047) begin
            rnd_sat = 12'sh7ff;
        end else if (r < -40'sd2048) begin
            rnd_sat = 12'sh800;
        end else begin
            rnd_sat = r[11:0];
        end
    endfunction

    // ------------------------------------------------------------
    // decimation phase
    // ------------------------------------------------------------
    logic dec_phase_reg;
    logic fire_reg;
    logic s1_valid_reg;
    logic signed [11:0] smp_in [0:1];
    logic signed [11:0] s1_data_reg [0:1];

    assign smp_in[0] = ADC_A;
    assign smp_in[1] = ADC_B;

    // every second accepted sample fires the filter
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dec_phase_reg <= 1'b0;
        end else if (!DEC_ENABLE) begin
            dec_phase_reg <= 1'b0;
        end else if (ADC_VALID) begin
            dec_phase_reg <= ~dec_phase_reg;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            fire_reg <= 1'b0;
        end else begin
            fire_reg <= DEC_ENABLE & ADC_VALID & dec_phase_reg;
        end
    end

    // filtered word lands one cycle after the firing sample; bypass loads the sample itself, one cycle sooner
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s1_valid_reg <= 1'b0;
        end else begin
            s1_valid_reg <= DEC_ENABLE ? fire_reg : ADC_VALID;
        end
    end

    // ------------------------------------------------------------
    // per-channel half-band filter
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic signed [11:0] line_reg [0:rdfm_pkg::TAPS-1];
            logic signed [39:0] fir_sum;
            logic signed [12:0] pair;

            // delay line keeps shifting in bypass so a later enable starts warm
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    for (int k = 0; k < rdfm_pkg::TAPS; k++) begin
                        line_reg[k] <= rdfm_pkg::SMP_RST;
                    end
                end else if (ADC_VALID) begin
                    line_reg[0] <= smp_in[ch];
                    for (int k = 1; k < rdfm_pkg::TAPS; k++) begin
                        line_reg[k] <= line_reg[k-1];
                    end
                end
            end

            // only the 11 pairs at even offsets and the centre are multiplied
            always_comb begin
                fir_sum = 40'sh0;
                pair = 13'sh0;
                for (int p = 0; p < rdfm_pkg::NZ_PAIRS; p++) begin
                    pair = 13'(line_reg[2*p]) + 13'(line_reg[rdfm_pkg::TAPS-1-2*p]);
                    fir_sum = fir_sum + 40'(pair) * 40'(rdfm_pkg::COEF[p]);
                end
                fir_sum = fir_sum + 40'(line_reg[rdfm_pkg::CENTRE]) * 40'(rdfm_pkg::COEF[rdfm_pkg::NZ_PAIRS]);
            end

            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    s1_data_reg[ch] <= rdfm_pkg::SMP_RST;
                end else if (DEC_ENABLE && fire_reg) begin
                    s1_data_reg[ch] <= rnd_sat(fir_sum, rdfm_pkg::DEC_SHIFT);
                end else if (!DEC_ENABLE && ADC_VALID) begin
                    s1_data_reg[ch] <= smp_in[ch];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // numerically controlled oscillator
    // ------------------------------------------------------------
    logic [31:0] phase_acc_reg;
    logic [31:0] nco_phase;
    logic signed [15:0] cos_val;
    logic signed [15:0] sin_val;

    // signed wrap-around of the unsigned add gives the +-half-rate span
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            phase_acc_reg <= rdfm_pkg::PHASE_ACC_RST;
        end else if (s1_valid_reg) begin
            phase_acc_reg <= phase_acc_reg + NCO_FREQ;
        end
    end

    assign nco_phase = phase_acc_reg + {NCO_PHASE, 12'h000};

    // lower accumulator bits are truncated; they still steer the frequency
    rdfm_nco_sincos u_sincos (
        .phase(nco_phase[31:16]),
        .cos_out(cos_val),
        .sin_out(sin_val)
    );

    // ------------------------------------------------------------
    // fine complex mixer
    // ------------------------------------------------------------
    logic signed [39:0] mix_i;
    logic signed [39:0] mix_q;

    always_comb begin
        mix_i = 40'(s1_data_reg[0]) * 40'(cos_val) - 40'(s1_data_reg[1]) * 40'(sin_val);
        mix_q = 40'(s1_data_reg[0]) * 40'(sin_val) + 40'(s1_data_reg[1]) * 40'(cos_val);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            OUT_I <= rdfm_pkg::SMP_RST;
            OUT_Q <= rdfm_pkg::SMP_RST;
        end else if (s1_valid_reg) begin
            OUT_I <= rnd_sat(mix_i, rdfm_pkg::MIX_SHIFT);
            OUT_Q <= rnd_sat(mix_q, rdfm_pkg::MIX_SHIFT);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            OUT_VALID <= 1'b0;
        end else begin
            OUT_VALID <= s1_valid_reg;
        end
    end

endmodule

`default_nettype wire

/* File: sim/rdfm_checker.sv */
// port assertions for the decimator and fine mixer
`timescale 1ns/1ps
`default_nettype none
module rdfm_checker (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // stream in
    input wire logic signed [11:0] ADC_A,
    input wire logic signed [11:0] ADC_B,
    input wire logic ADC_VALID,
    input wire logic DEC_ENABLE,
    // stream out
    input wire logic signed [11:0] OUT_I,
    input wire logic signed [11:0] OUT_Q,
    input wire logic OUT_VALID
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_byp;
        ADC_VALID && !DEC_ENABLE ##1 !DEC_ENABLE;
    endsequence
    sequence s_dec_out;
        DEC_ENABLE [*4] ##0 OUT_VALID;
    endsequence
    a_byp_latency: assert property (s_byp |=> OUT_VALID)
        else $error("bypass sample gave no output");
    a_byp_source: assert property ((!DEC_ENABLE) [*3] ##0 OUT_VALID |-> $past(ADC_VALID, 2))
        else $error("bypass output without input");
    a_zero_mix: assert property ((ADC_A == 0 && ADC_B == 0) ##0 s_byp |=> OUT_I == 0 && OUT_Q == 0)
        else $error("zero input mixed to nonzero");
    a_dec_halves: assert property (s_dec_out |=> !OUT_VALID)
        else $error("decimated outputs back to back");
    a_dec_source: assert property (s_dec_out |-> $past(ADC_VALID, 3))
        else $error("decimated output without input");
    a_out_cause: assert property (OUT_VALID |-> $past(ADC_VALID, 2) || $past(ADC_VALID, 3))
        else $error("output without any input");
    a_out_hold: assert property (!OUT_VALID |-> $stable(OUT_I) && $stable(OUT_Q))
        else $error("output moved between samples");
    a_reset_clear: assert property (disable iff (1'b0) !RST_N |-> !OUT_VALID && OUT_I == 0 && OUT_Q == 0)
        else $error("outputs not cleared in reset");
endmodule
bind rdfm_top rdfm_checker u_chk (.CLK(CLK), .RST_N(RST_N), .ADC_A(ADC_A), .ADC_B(ADC_B), .ADC_VALID(ADC_VALID),
    .DEC_ENABLE(DEC_ENABLE), .OUT_I(OUT_I), .OUT_Q(OUT_Q), .OUT_VALID(OUT_VALID));
`default_nettype wire

/* File: sim/rdfm_adc_model.sv */
// sample source standing in for the two converters
`timescale 1ns/1ps
`default_nettype none
module rdfm_adc_model (
    // clock
    input wire logic clk,
    // sample stream
    output logic signed [11:0] adc_a,
    output logic signed [11:0] adc_b,
    output logic adc_valid
);
    logic slow = 1'b0;
    initial begin
        adc_a = 12'h000;
        adc_b = 12'h000;
        adc_valid = 1'b0;
    end
    // idle lines show inverted data so stale values never pass
    task automatic idle;
        @(negedge clk);
        adc_a = ~adc_a;
        adc_b = ~adc_b;
        adc_valid = 1'b0;
    endtask
    task automatic send(input logic signed [11:0] a, input logic signed [11:0] b);
        if (slow) idle();
        @(negedge clk);
        adc_a = a;
        adc_b = b;
        adc_valid = 1'b1;
    endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the decimator and fine mixer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // clock starts high so reset falls before the first rising edge
    logic clk = 1'b1;
    logic rst_n = 1'b1;
    logic dec_enable = 1'b0;
    logic [31:0] nco_freq = 32'h0000_0000;
    logic [19:0] nco_phase = 20'h00000;
    wire logic signed [11:0] adc_a, adc_b, out_i, out_q;
    wire logic adc_valid, out_valid;
    int n_errors = 0;
    int n_compared = 0;
    logic signed [11:0] cap_i [$];
    logic signed [11:0] cap_q [$];
    always #50 clk = ~clk;
    rdfm_adc_model src (.clk(clk), .adc_a(adc_a), .adc_b(adc_b), .adc_valid(adc_valid));
    rdfm_top dut (.CLK(clk), .RST_N(rst_n), .ADC_A(adc_a), .ADC_B(adc_b), .ADC_VALID(adc_valid),
        .DEC_ENABLE(dec_enable), .NCO_FREQ(nco_freq), .NCO_PHASE(nco_phase),
        .OUT_I(out_i), .OUT_Q(out_q), .OUT_VALID(out_valid));
    always @(negedge clk) begin
        if (out_valid === 1'b1) begin
            cap_i.push_back(out_i);
            cap_q.push_back(out_q);
        end
    end
    task automatic final_report;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bad(input string msg);
        n_errors++;
        $display("BAD %0t %s", $time, msg);
    endtask
    // cordic error allows a couple of lsb
    task automatic chk(input logic signed [11:0] got, input int exp);
        n_compared++;
        if ((^got) === 1'bx || int'(got) > exp + 2 || int'(got) < exp - 2) bad($sformatf("got %0d want %0d", got, exp));
    endtask
    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        cap_i.delete();
        cap_q.delete();
    endtask
    task automatic wait_out(input int n);
        for (int k = 0; k < 300 && cap_i.size() < n; k++) @(negedge clk);
        if (cap_i.size() < n) begin
            bad("output missing");
            final_report();
        end
    endtask
    task automatic t_mix;
        logic [19:0] ph [5] = '{20'h00000, 20'h40000, 20'hc0000, 20'h20000, 20'h20000};
        int ei [5] = '{500, 300, -300, 2047, 0};
        int eq [5] = '{-300, 500, -500, -1, 0};
        for (int i = 0; i < 5; i++) begin
            nco_phase = ph[i];
            cap_i.delete();
            cap_q.delete();
            if (i < 3) src.send(12'h1f4, 12'hed4);
            else if (i == 3) src.send(12'h7ff, 12'h800);
            else src.send(12'h000, 12'h000);
            src.idle();
            wait_out(1);
            chk(cap_i[0], ei[i]);
            chk(cap_q[0], eq[i]);
        end
    endtask
    task automatic t_freq;
        int ei [4] = '{1000, 0, -1000, 0};
        for (int s = 0; s < 2; s++) begin
            nco_freq = s ? 32'hc000_0000 : 32'h4000_0000;
            nco_phase = 20'h00000;
            do_reset();
            src.slow = s[0];
            repeat (4) src.send(12'h3e8, 12'h000);
            src.idle();
            wait_out(4);
            for (int k = 0; k < 4; k++) begin
                chk(cap_i[k], ei[k]);
                chk(cap_q[k], (s ? -1 : 1) * ei[(k + 3) % 4]);
            end
        end
        src.slow = 1'b0;
    endtask
    task automatic t_halfband;
        int c;
        dec_enable = 1'b1;
        nco_freq = 32'h0000_0000;
        do_reset();
        src.send(12'h7ff, 12'h000);
        src.send(12'h000, 12'h7ff);
        repeat (44) src.send(12'h000, 12'h000);
        src.idle();
        wait_out(23);
        repeat (8) @(negedge clk);
        n_compared++;
        if (cap_i.size() != 23) bad("wrong decimated count");
        for (int m = 0; m < 23; m++) begin
            c = m < 11 ? rdfm_pkg::COEF[m] : (m < 22 ? rdfm_pkg::COEF[21 - m] : 0);
            chk(cap_i[m], m == 10 ? 1024 : 0);
            chk(cap_q[m], (c * 2047 + 32768) >>> 16);
        end
        dec_enable = 1'b0;
    endtask
    initial begin
        do_reset();
        t_mix();
        t_freq();
        t_halfband();
        final_report();
    end
endmodule
`default_nettype wire
